// *** pkg/iir_defs.vh ***
/*
 holds the offsets, field positions, reset values and cycle counts of the
 instruction slice executor; assumes plain Verilog-2005 inclusion by bare name.
*/
`ifndef IIR_DEFS_VH
`define IIR_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets (word aligned, 32-bit bus)
`define IIR_OFS_INSTR 11'h000
`define IIR_OFS_CTRL 11'h004
`define IIR_OFS_STATUS 11'h008
`define IIR_OFS_PC 11'h010
`define IIR_OFS_SP 11'h014
`define IIR_OFS_TP 11'h018
`define IIR_OFS_SYM 11'h01c
`define IIR_OFS_SHADOW 11'h020
// register file window: byte n of the file sits at RF_BASE + 4*n
`define IIR_RF_BIT 10
`define IIR_FLAGS_ADDR 8'hd5
`define IIR_WREG_HI 4'hc

////////////////////////////////////////////////////////////////////////////////
// field positions
`define IIR_CTRL_START 0
`define IIR_ST_ILLEGAL 2
`define IIR_FL_Z 6
`define IIR_FL_S 5
`define IIR_FL_V 4
`define IIR_FL_FIS 1
`define IIR_SYM_GIE 0

////////////////////////////////////////////////////////////////////////////////
// reset values
`define IIR_RST_BYTE 8'h00
`define IIR_RST_WORD 16'h0000
`define IIR_RST_INSTR 24'h000000

////////////////////////////////////////////////////////////////////////////////
// opcodes
`define IIR_OP_IDLE 8'h6f
`define IIR_OP_INC_R 8'h20
`define IIR_OP_INC_IR 8'h21
`define IIR_OP_ADD_ONE_WORD_OP_RR 8'ha0
`define IIR_OP_ADD_ONE_WORD_OP_IR 8'ha1
`define IIR_OP_SERVICE_RETURN_OP 8'hbf
`define IIR_OP_JP_IRR 8'h30
`define IIR_LO_INC_WR 4'he
`define IIR_LO_JP_CC 4'hd
`define IIR_LO_JR_CC 4'hb

////////////////////////////////////////////////////////////////////////////////
// execution lengths in cpu cycles
`define IIR_CYC_IDLE 4'd4
`define IIR_CYC_INC 4'd4
`define IIR_CYC_ADD_ONE_WORD_OP 4'd8
`define IIR_CYC_SERVICE_RETURN_OP_N 4'd10
`define IIR_CYC_SERVICE_RETURN_OP_F 4'd6
`define IIR_CYC_JP 4'd8
`define IIR_CYC_JR 4'd6
`define IIR_CYC_BAD 4'd4

`endif

// *** rtl/iir_inc_unit.v ***
/*
 byte or word increment with zero, sign and overflow results;
 assumes the caller places the high byte at the even address in din[15:8].
*/
module iir_inc_unit (
   input wire word_mode, // 1: 16-bit increment, 0: byte in din[7:0]
   input wire [15:0] din, // operand
   output wire [15:0] dout, // incremented value
   output wire zero, // result is zero
   output wire sign, // result msb
   output wire ovf // positive operand wrapped to negative
);
   wire [7:0] lo_sum;
   wire lo_carry;
   wire [7:0] hi_sum;

   assign {lo_carry, lo_sum} = {1'b0, din[7:0]} + 9'h001;
   // low byte carry advances the high byte
   assign hi_sum = din[15:8] + {7'h00, lo_carry};
   assign dout = word_mode ? {hi_sum, lo_sum} : {din[15:8], lo_sum};
   assign zero = word_mode ? (dout == 16'h0000) : (lo_sum == 8'h00);
   assign sign = word_mode ? hi_sum[7] : lo_sum[7];
   assign ovf = word_mode ? (dout == 16'h8000) : (lo_sum == 8'h80);
endmodule // iir_inc_unit

// *** rtl/iir_exec.v ***
/*
 executor for the idle, increment, interrupt return and branch slice, with a
 256-byte register file and an ahb-lite register slave; assumes a single
 master, word transfers only, and a condition table outside that answers cond_true.
*/
// Added by the designer: the AHB-Lite slave port and the register offsets.
`include "iir_defs.vh"

// Notes on behaviour
// - idle opcode runs 4 cycles, then gates cpu clock off; flags untouched
// - halted core wakes only on interrupt request or external reset
// - byte increment adds one, sets zero, sign, overflow; others kept
// - byte increment forms: working register nibble, 20 direct, 21 indirect
// - word increment on even pair, 8 cycles, A0 pair or A1 indirect
// - normal return pops flags, then pc, sp up by three, enables interrupts
// - normal return only when fast service status flag bit one clear
// - fast return swaps pc and thread_pointer, restores shadow flags, clears status
// - conditional absolute branch loads direct address when condition holds, 8 cycles
// - opcode 30 loads pc from indirectly addressed register pair
// - relative branch adds signed displacement when condition holds, 6 cycles
// - displacement -128 to +127 added to address after the instruction
// - idle and all branches leave flags unchanged
// - system mode bit zero is the global interrupt enable
module iir_exec (
   input wire hclk, // 40 MHz clock
   input wire hresetn, // async reset, active low
   input wire hsel, // slave select
   input wire [31:0] haddr, // byte address
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write transfer
   input wire [2:0] hsize, // transfer size, word only
   input wire [31:0] hwdata, // write data
   input wire hready, // bus ready
   output wire hreadyout, // slave ready, no wait states
   output wire hresp, // always okay
   output reg [31:0] hrdata, // read data
   input wire irq_req, // interrupt request level
   input wire cond_true, // condition named by cond_code holds
   output wire [3:0] cond_code, // condition_code of current branch
   output wire cpu_clk_en, // cpu clock gate enable
   output wire busy // instruction in progress
);
   localparam ST_READY = 2'd0;
   localparam ST_EXEC = 2'd1;
   localparam ST_HALT = 2'd2;

   reg [7:0] rf [0:255];
   reg [1:0] state_reg;
   reg [3:0] cnt_reg;
   reg [23:0] instr_reg;
   reg [15:0] pc_reg;
   reg [15:0] stack_pointer_reg;
   reg [15:0] thread_pointer_reg;
   reg [7:0] flags_reg;
   reg [7:0] shadow_reg;
   reg [7:0] system_mode_reg;
   reg illegal_reg;
   reg ap_valid_reg;
   reg ap_write_reg;
   reg [10:0] ap_addr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire [7:0] opc = instr_reg[7:0];
   wire [7:0] b1 = instr_reg[15:8];
   wire [7:0] b2 = instr_reg[23:16];
   wire is_idle = (opc == `IIR_OP_IDLE);
   wire is_inc_wr = (opc[3:0] == `IIR_LO_INC_WR);
   wire is_inc = is_inc_wr || (opc == `IIR_OP_INC_R) || (opc == `IIR_OP_INC_IR);
   wire is_add_one_word_op = (opc == `IIR_OP_ADD_ONE_WORD_OP_RR) || (opc == `IIR_OP_ADD_ONE_WORD_OP_IR);
   wire is_service_return_op = (opc == `IIR_OP_SERVICE_RETURN_OP);
   wire is_jp_cc = (opc[3:0] == `IIR_LO_JP_CC);
   wire is_jp_irr = (opc == `IIR_OP_JP_IRR);
   wire is_jr = (opc[3:0] == `IIR_LO_JR_CC);
   wire fast_ret = flags_reg[`IIR_FL_FIS];
   wire known = is_idle | is_inc | is_add_one_word_op | is_service_return_op | is_jp_cc | is_jp_irr | is_jr;

   reg [3:0] cycles;
   reg [15:0] seq_pc;
   always @* begin
      cycles = `IIR_CYC_BAD;
      seq_pc = pc_reg + 16'h0001;
      if (is_idle) begin
         cycles = `IIR_CYC_IDLE;
      end else if (is_inc) begin
         cycles = `IIR_CYC_INC;
         seq_pc = is_inc_wr ? pc_reg + 16'h0001 : pc_reg + 16'h0002;
      end else if (is_add_one_word_op) begin
         cycles = `IIR_CYC_ADD_ONE_WORD_OP;
         seq_pc = pc_reg + 16'h0002;
      end else if (is_service_return_op) begin
         cycles = fast_ret ? `IIR_CYC_SERVICE_RETURN_OP_F : `IIR_CYC_SERVICE_RETURN_OP_N;
      end else if (is_jp_cc) begin
         cycles = `IIR_CYC_JP;
         seq_pc = pc_reg + 16'h0003;
      end else if (is_jp_irr) begin
         cycles = `IIR_CYC_JP;
         seq_pc = pc_reg + 16'h0002;
      end else if (is_jr) begin
         cycles = `IIR_CYC_JR;
         seq_pc = pc_reg + 16'h0002;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand addressing and increment
   reg [7:0] dst_addr;
   always @* begin
      dst_addr = b1;
      if (is_inc_wr) begin
         dst_addr = {`IIR_WREG_HI, opc[7:4]};
      end else if (opc == `IIR_OP_INC_IR) begin
         dst_addr = rf[b1];
      end else if (opc == `IIR_OP_ADD_ONE_WORD_OP_RR) begin
         dst_addr = {b1[7:1], 1'b0};
      end else if (opc == `IIR_OP_ADD_ONE_WORD_OP_IR) begin
         dst_addr = {rf[b1][7:1], 1'b0};
      end
   end

   wire [7:0] dst_addr1 = dst_addr + 8'h01;
   wire [15:0] inc_in = is_add_one_word_op ? {rf[dst_addr], rf[dst_addr1]} : {8'h00, rf[dst_addr]};
   wire [15:0] inc_out;
   wire inc_z;
   wire inc_s;
   wire inc_v;

   iir_inc_unit u_inc (
      .word_mode(is_add_one_word_op),
      .din(inc_in),
      .dout(inc_out),
      .zero(inc_z),
      .sign(inc_s),
      .ovf(inc_v)
   );

   wire [7:0] sp8 = stack_pointer_reg[7:0];
   wire [7:0] sp8_1 = sp8 + 8'h01;
   wire [7:0] sp8_2 = sp8 + 8'h02;
   wire [7:0] b1_1 = b1 + 8'h01;
   wire [15:0] jr_target = seq_pc + {{8{b1[7]}}, b1};
   wire [15:0] jp_ind_target = {rf[b1], rf[b1_1]};

   ////////////////////////////////////////////////////////////////////////////
   // sequencer
   wire finish = (state_reg == ST_EXEC) && (cnt_reg == 4'd0);
   wire rf_wr0 = finish && (is_inc || is_add_one_word_op);
   wire rf_wr1 = finish && is_add_one_word_op;

   assign cond_code = opc[7:4];
   assign busy = (state_reg != ST_READY);
   assign cpu_clk_en = (state_reg != ST_HALT);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire ap_take = hsel && hready && htrans[1];
   wire dp_wr = ap_valid_reg && ap_write_reg;
   wire sw_ok = dp_wr && (state_reg == ST_READY);
   wire rf_win = ap_addr_reg[`IIR_RF_BIT];
   wire [7:0] rf_idx = ap_addr_reg[9:2];
   wire flags_hit = rf_win && (rf_idx == `IIR_FLAGS_ADDR);
   wire start = sw_ok && !rf_win && (ap_addr_reg == `IIR_OFS_CTRL) && hwdata[`IIR_CTRL_START];
   wire clr_illegal = dp_wr && !rf_win && (ap_addr_reg == `IIR_OFS_STATUS) && hwdata[`IIR_ST_ILLEGAL];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_READY;
         cnt_reg <= 4'd0;
      end else begin
         case (state_reg)
            ST_READY: begin
               if (start) begin
                  state_reg <= ST_EXEC;
                  // counts down to zero on the last executing cycle
                  cnt_reg <= cycles - 4'd1;
               end else begin
                  cnt_reg <= 4'd0;
               end
            end
            ST_EXEC: begin
               if (finish) begin
                  state_reg <= is_idle ? ST_HALT : ST_READY;
               end else begin
                  cnt_reg <= cnt_reg - 4'd1;
               end
            end
            ST_HALT: begin
               if (irq_req) begin
                  state_reg <= ST_READY;
               end
            end
            default: begin
               state_reg <= ST_READY;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // architectural registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         instr_reg <= `IIR_RST_INSTR;
         pc_reg <= `IIR_RST_WORD;
         stack_pointer_reg <= `IIR_RST_WORD;
         thread_pointer_reg <= `IIR_RST_WORD;
         flags_reg <= `IIR_RST_BYTE;
         shadow_reg <= `IIR_RST_BYTE;
         system_mode_reg <= `IIR_RST_BYTE;
         illegal_reg <= 1'b0;
      end else begin
         if (sw_ok && !rf_win) begin
            case (ap_addr_reg)
               `IIR_OFS_INSTR: instr_reg <= hwdata[23:0];
               `IIR_OFS_PC: pc_reg <= hwdata[15:0];
               `IIR_OFS_SP: stack_pointer_reg <= hwdata[15:0];
               `IIR_OFS_TP: thread_pointer_reg <= hwdata[15:0];
               `IIR_OFS_SYM: system_mode_reg <= hwdata[7:0];
               `IIR_OFS_SHADOW: shadow_reg <= hwdata[7:0];
               default: begin
               end
            endcase
         end
         if (sw_ok && flags_hit) begin
            flags_reg <= hwdata[7:0];
         end
         // a new undecodable opcode outranks a clear in the same cycle
         if (finish && !known) begin
            illegal_reg <= 1'b1;
         end else if (clr_illegal) begin
            illegal_reg <= 1'b0;
         end
         if (finish) begin
            pc_reg <= seq_pc;
            if (is_inc || is_add_one_word_op) begin
               flags_reg[`IIR_FL_Z] <= inc_z;
               flags_reg[`IIR_FL_S] <= inc_s;
               flags_reg[`IIR_FL_V] <= inc_v;
            end
            if (is_service_return_op && !fast_ret) begin
               flags_reg <= rf[sp8];
               pc_reg <= {rf[sp8_1], rf[sp8_2]};
               stack_pointer_reg <= stack_pointer_reg + 16'h0003;
               system_mode_reg[`IIR_SYM_GIE] <= 1'b1;
            end
            if (is_service_return_op && fast_ret) begin
               pc_reg <= thread_pointer_reg;
               thread_pointer_reg <= pc_reg;
               flags_reg <= shadow_reg & ~(8'h01 << `IIR_FL_FIS);
            end
            if (is_jp_cc && cond_true) begin
               pc_reg <= {b1, b2};
            end
            if (is_jp_irr) begin
               pc_reg <= jp_ind_target;
            end
            if (is_jr && cond_true) begin
               pc_reg <= jr_target;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register file: execution writes, or software while the core is ready
   always @(posedge hclk) begin
      if (rf_wr0) begin
         rf[dst_addr] <= is_add_one_word_op ? inc_out[15:8] : inc_out[7:0];
      end
      if (rf_wr1) begin
         rf[dst_addr1] <= inc_out[7:0];
      end
      if (sw_ok && rf_win && !flags_hit) begin
         rf[rf_idx] <= hwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: address phase capture and registered read data
   wire [10:0] rd_addr = haddr[10:0];
   wire [7:0] rd_idx = rd_addr[9:2];
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (rd_addr[`IIR_RF_BIT]) begin
         rd_mux = {24'h000000, (rd_idx == `IIR_FLAGS_ADDR) ? flags_reg : rf[rd_idx]};
      end else begin
         case (rd_addr)
            `IIR_OFS_INSTR: rd_mux = {8'h00, instr_reg};
            `IIR_OFS_STATUS: rd_mux = {24'h000000, cnt_reg, 1'b0, illegal_reg, state_reg};
            `IIR_OFS_PC: rd_mux = {16'h0000, pc_reg};
            `IIR_OFS_SP: rd_mux = {16'h0000, stack_pointer_reg};
            `IIR_OFS_TP: rd_mux = {16'h0000, thread_pointer_reg};
            `IIR_OFS_SYM: rd_mux = {24'h000000, system_mode_reg};
            `IIR_OFS_SHADOW: rd_mux = {24'h000000, shadow_reg};
            default: rd_mux = 32'h00000000;
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_reg <= 1'b0;
         ap_write_reg <= 1'b0;
         ap_addr_reg <= 11'h000;
         hrdata <= 32'h00000000;
      end else begin
         if (hready) begin
            ap_valid_reg <= ap_take;
            ap_write_reg <= hwrite;
            ap_addr_reg <= {haddr[10:2], 2'b00};
         end
         if (ap_take && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end
endmodule // iir_exec

// *** tb/iir_exec_monitor.sv ***
/*
 port checker for iir_exec: execution lengths, halt and wake, condition code.
 assumes single-master ahb-lite traffic and the hand-over timing of iir_exec.
*/
`include "iir_defs.vh"
module iir_exec_monitor (
   input wire hclk, // clock
   input wire hresetn, // reset, low
   input wire hsel, // select
   input wire [31:0] haddr, // address
   input wire [1:0] htrans, // transfer type
   input wire hwrite, // write
   input wire [31:0] hwdata, // write data
   input wire hready, // bus ready
   input wire irq_req, // interrupt request
   input wire [3:0] cond_code, // condition code
   input wire cpu_clk_en, // cpu clock gate
   input wire busy // executing
);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
////////////////////////////////////////////////////////////////////////////////
// mirror of the latched opcode; writes while busy are refused
reg wr_ap_reg;
reg [7:0] op_reg;
always @(posedge hclk or negedge hresetn) begin
   if (!hresetn) begin
      wr_ap_reg <= 1'b0;
      op_reg <= 8'h00;
   end else begin
      wr_ap_reg <= hsel && hready && htrans[1] && hwrite && haddr[10:0] == `IIR_OFS_INSTR;
      if (wr_ap_reg && !busy) begin
         op_reg <= hwdata[7:0];
      end
   end
end
////////////////////////////////////////////////////////////////////////////////
property p_idle_len;
   $rose(busy) && op_reg == `IIR_OP_IDLE |-> cpu_clk_en [*4] ##1 !cpu_clk_en;
endproperty
a_idle_len: assert property (p_idle_len) else $error("idle length wrong");
property p_halt_hold;
   !cpu_clk_en && !irq_req |=> !cpu_clk_en && busy;
endproperty
a_halt_hold: assert property (p_halt_hold) else $error("left halt without request");
property p_wake;
   !cpu_clk_en && irq_req |=> cpu_clk_en && !busy;
endproperty
a_wake: assert property (p_wake) else $error("no wake on request");
property p_inc_len;
   $rose(busy) && (op_reg[3:0] == `IIR_LO_INC_WR || op_reg == `IIR_OP_INC_R || op_reg == `IIR_OP_INC_IR)
      |-> busy [*4] ##1 !busy;
endproperty
a_inc_len: assert property (p_inc_len) else $error("increment length wrong");
property p_add_one_word_op_len;
   $rose(busy) && (op_reg == `IIR_OP_ADD_ONE_WORD_OP_RR || op_reg == `IIR_OP_ADD_ONE_WORD_OP_IR) |-> busy [*8] ##1 !busy;
endproperty
a_add_one_word_op_len: assert property (p_add_one_word_op_len) else $error("word increment length wrong");
property p_jp_len;
   $rose(busy) && (op_reg[3:0] == `IIR_LO_JP_CC || op_reg == `IIR_OP_JP_IRR) |-> busy [*8] ##1 !busy;
endproperty
a_jp_len: assert property (p_jp_len) else $error("absolute branch length wrong");
property p_jr_len;
   $rose(busy) && op_reg[3:0] == `IIR_LO_JR_CC |-> busy [*6] ##1 !busy;
endproperty
a_jr_len: assert property (p_jr_len) else $error("relative branch length wrong");
property p_ret_len;
   $rose(busy) && op_reg == `IIR_OP_SERVICE_RETURN_OP |-> busy [*6] ##1 (!busy or busy [*4] ##1 !busy);
endproperty
a_ret_len: assert property (p_ret_len) else $error("return length wrong");
property p_cond;
   busy |-> cond_code == op_reg[7:4];
endproperty
a_cond: assert property (p_cond) else $error("condition code not opcode nibble");
endmodule // iir_exec_monitor
bind iir_exec iir_exec_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .irq_req(irq_req),
   .cond_code(cond_code), .cpu_clk_en(cpu_clk_en), .busy(busy));

// *** tb/idle_inc_service_return_op_jump_exec_test.sv ***
/*
 self-checking bench for iir_exec: ahb-lite master, condition and interrupt inputs.
 assumes the checker is bound from iir_exec_monitor.sv.
*/
`include "iir_defs.vh"
module idle_inc_service_return_op_jump_exec_test;
timeunit 1ns;
timeprecision 1ps;
reg hclk = 1'b0;
reg hresetn = 1'b0;
reg hsel = 1'b0;
reg [31:0] haddr = 32'h0;
reg [1:0] htrans = 2'h0;
reg hwrite = 1'b0;
reg [31:0] hwdata = 32'h0;
reg irq_req = 1'b0;
reg cond_true = 1'b0;
reg rd_dp = 1'b0;
reg t;
reg [7:0] r;
wire hready;
wire hresp;
wire [31:0] hrdata;
wire [3:0] cond_code;
wire cpu_clk_en;
wire busy;
integer num_errors = 0;
integer checked = 0;
integer i;
reg [31:0] exp_q[$];
localparam [31:0] a_pc = `IIR_OFS_PC;
localparam [31:0] a_fl = 32'h400 + 4 * `IIR_FLAGS_ADDR;
always #12.5 hclk = ~hclk;
iir_exec uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
   .irq_req(irq_req), .cond_true(cond_true), .cond_code(cond_code), .cpu_clk_en(cpu_clk_en), .busy(busy));
////////////////////////////////////////////////////////////////////////////////
task results;
   begin
      if (num_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
endtask
task chk(input [31:0] got, input [31:0] exp);
   begin
      checked = checked + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
endtask
// read results are compared against the oldest note when their data phase ends
always @(posedge hclk) begin
   if (rd_dp && hready === 1'b1) begin
      chk(hrdata, exp_q.pop_front());
      chk({31'h0, hresp}, 32'h0);
   end
   rd_dp <= hsel && hready && htrans[1] && !hwrite;
end
////////////////////////////////////////////////////////////////////////////////
task ahb(input [31:0] a, input w, input [31:0] d);
   integer n, p;
   begin
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      for (p = 0; p < 2; p = p + 1) begin
         n = 0;
         do begin
            @(posedge hclk);
            n = n + 1;
         end while (hready !== 1'b1 && n < 50);
         if (n >= 50) begin
            num_errors = num_errors + 1;
            results;
         end
         htrans <= 2'h0;
         hwdata <= d;
      end
   end
endtask
task wr(input [31:0] a, input [31:0] d);
   ahb(a, 1'b1, d);
endtask
task rd(input [31:0] a, input [31:0] e);
   begin
      exp_q.push_back(e);
      ahb(a, 1'b0, 32'h0);
   end
endtask
function [31:0] ra(input [7:0] n);
   ra = 32'h400 + {22'h0, n, 2'b00};
endfunction
// start an instruction and count its executing cycles
task go(input [23:0] ins, input [31:0] cyc);
   integer n, k;
   begin
      wr(`IIR_OFS_INSTR, {8'h00, ins});
      wr(`IIR_OFS_CTRL, 32'h1);
      n = 0;
      for (k = 0; k < 40 && (n == 0 || busy && cpu_clk_en); k = k + 1) begin
         @(negedge hclk);
         if (busy === 1'b1 && cpu_clk_en === 1'b1) n = n + 1;
      end
      chk(n, cyc);
   end
endtask
task inc(input [23:0] ins, input [7:0] a, input [15:0] v, input [15:0] e, input [7:0] fl, input w);
   begin
      wr(a_fl, 32'h8c);
      wr(ra(a), w ? v[15:8] : v[7:0]);
      if (w) wr(ra(a + 8'h1), v[7:0]);
      go(ins, w ? 8 : 4);
      rd(ra(a), w ? e[15:8] : e[7:0]);
      if (w) rd(ra(a + 8'h1), e[7:0]);
      rd(a_fl, fl);
   end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
   r = $urandom(79);
   repeat (20) @(posedge hclk);
   hresetn <= 1'b1;
   rd(a_pc, 32'h0);
   rd(`IIR_OFS_SP, 32'h0);
   rd(32'h100, 32'h0);
   inc(24'h00003e, 8'hc3, 16'h7f, 16'h80, 8'hbc, 1'b0);
   inc(24'h003020, 8'h30, 16'hff, 16'h00, 8'hcc, 1'b0);
   r = $urandom_range(8'h7d, 0);
   wr(ra(8'h31), 32'h32);
   inc(24'h003121, 8'h32, {8'h0, r}, {8'h0, r + 8'h1}, 8'h8c, 1'b0);
   inc(24'h0040a0, 8'h40, 16'h12ff, 16'h1300, 8'h8c, 1'b1);
   wr(ra(8'h50), 32'h44);
   inc(24'h0050a1, 8'h44, 16'h7fff, 16'h8000, 8'hbc, 1'b1);
   inc(24'h0040a0, 8'h40, 16'hffff, 16'h0000, 8'hcc, 1'b1);
   for (i = 0; i < 16; i = i + 1) begin
      t = $urandom;
      cond_true <= t;
      wr(a_pc, 32'h1000);
      go({16'h3412, i[3:0], 4'hd}, 8);
      rd(a_pc, t ? 32'h1234 : 32'h1003);
      wr(a_pc, 32'h1ff0);
      go({8'h00, i[0] ? 8'h80 : 8'h7f, i[3:0], 4'hb}, 6);
      rd(a_pc, t ? (i[0] ? 32'h1f72 : 32'h2071) : 32'h1ff2);
   end
   rd(a_fl, 32'hcc);
   wr(ra(8'h60), 32'h01);
   wr(ra(8'h61), 32'h20);
   go(24'h006030, 8);
   rd(a_pc, 32'h0120);
   wr(`IIR_OFS_SP, 32'h70);
   wr(ra(8'h70), 32'h55);
   wr(ra(8'h71), 32'h23);
   wr(ra(8'h72), 32'h45);
   wr(`IIR_OFS_SYM, 32'h0);
   wr(a_fl, 32'h0);
   go(24'h0000bf, 10);
   rd(a_pc, 32'h2345);
   rd(`IIR_OFS_SP, 32'h73);
   rd(`IIR_OFS_SYM, 32'h1);
   rd(a_fl, 32'h55);
   wr(`IIR_OFS_TP, 32'h100);
   wr(`IIR_OFS_SHADOW, 32'haa);
   wr(a_fl, 32'h02);
   go(24'h0000bf, 6);
   rd(a_pc, 32'h0100);
   rd(a_fl, 32'ha8);
   wr(a_pc, 32'h200);
   go(24'h00006f, 4);
   repeat (10) @(negedge hclk);
   chk({30'h0, busy, cpu_clk_en}, 32'h2);
   wr(`IIR_OFS_INSTR, 32'h3e);
   rd(`IIR_OFS_INSTR, 32'h6f);
   @(posedge hclk);
   irq_req <= 1'b1;
   @(posedge hclk);
   irq_req <= 1'b0;
   @(negedge hclk);
   chk({30'h0, busy, cpu_clk_en}, 32'h1);
   rd(a_pc, 32'h0201);
   rd(a_fl, 32'ha8);
   // three no_operation slots pass before the next start after wake
   repeat (3) @(posedge hclk);
   // undecodable opcode: sticky status flag, pc steps by one, write one clears
   wr(a_pc, 32'h300);
   go(24'h00008f, 4);
   rd(`IIR_OFS_STATUS, 32'h4);
   rd(a_pc, 32'h0301);
   wr(`IIR_OFS_STATUS, 32'h4);
   rd(`IIR_OFS_STATUS, 32'h0);
   repeat (3) @(posedge hclk);
   results;
end
endmodule // idle_inc_service_return_op_jump_exec_test
